// ### verilog/sbba_pkg.sv
package sbba_pkg;

    // ****************************************
    // array geometry
    // ****************************************
    localparam int BANK_BITS = 2;
    localparam int BANK_COUNT = 4;
    localparam int ROW_BITS = 13;
    localparam int ROW_COUNT = 8192;
    localparam int COLS_X4 = 4096;
    localparam int COLS_X8 = 2048;
    localparam int COLS_X16 = 1024;
    localparam int ADDR_BITS = 13;
    localparam int DQ_WIDTH = 16;
    localparam int LANE_COUNT = 2;
    localparam int FIFO_DEPTH = 8;

    // ****************************************
    // mode register fields and address bits
    // ****************************************
    localparam int MODE_LEN_LSB = 0;
    localparam int MODE_TYPE_BIT = 3;
    localparam int MODE_LAT_LSB = 4;
    localparam int MODE_SINGLE_WRITE_BIT = 9;
    localparam int PRECHARGE_SCOPE_BIT = 10;
    localparam logic [12:0] MODE_RESET = 13'h0020;
    localparam logic [2:0] BURST_CODE_2 = 3'h1;
    localparam logic [2:0] BURST_CODE_4 = 3'h2;
    localparam logic [2:0] BURST_CODE_8 = 3'h3;
    localparam logic [2:0] BURST_CODE_PAGE = 3'h7;
    localparam logic [2:0] LATENCY_THREE = 3'h3;

    // ****************************************
    // command codes on row, column, write strobes
    // ****************************************
    localparam logic [2:0] CODE_NOP = 3'h7;
    localparam logic [2:0] CODE_ACTIVE = 3'h3;
    localparam logic [2:0] CODE_READ = 3'h5;
    localparam logic [2:0] CODE_WRITE = 3'h4;
    localparam logic [2:0] CODE_TERMINATE = 3'h6;
    localparam logic [2:0] CODE_PRECHARGE = 3'h2;
    localparam logic [2:0] CODE_REFRESH = 3'h1;
    localparam logic [2:0] CODE_LOAD_MODE = 3'h0;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
        CMD_TERMINATE, CMD_PRECHARGE, CMD_REFRESH, CMD_LOAD_MODE
    } sbba_cmd_type;

    typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} sbba_burst_type;

    function automatic int col_bits(input int width);
        if (width == 4) begin
            return $clog2(COLS_X4);
        end
        if (width == 8) begin
            return $clog2(COLS_X8);
        end
        return $clog2(COLS_X16);
    endfunction

endpackage

// ### verilog/sbba_fifo.sv
`timescale 1ns/10ps
module sbba_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);

    logic [WIDTH-1:0] slot_q [DEPTH];
    logic [PTR_W:0] wrPtr_q;
    logic [PTR_W:0] rdPtr_q;
    logic [PTR_W:0] fill;

    assign fill = wrPtr_q - rdPtr_q;
    assign inReady = fill != FULL_COUNT;
    assign outValid = fill != '0;
    assign outData = slot_q[rdPtr_q[PTR_W-1:0]];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= '0;
        end else if (inValid && inReady) begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdPtr_q <= '0;
        end else if (outValid && outReady) begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (inValid && inReady) begin
            slot_q[wrPtr_q[PTR_W-1:0]] <= inData;
        end
    end

endmodule

// ### verilog/sbba_bank.sv
`timescale 1ns/10ps
module sbba_bank (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic activate,
    input wire logic precharge,
    input wire logic [12:0] rowIn,
    output logic rowOpen,
    output logic [12:0] openRow
);
    logic rowOpen_q;
    logic [12:0] openRow_q;

    assign rowOpen = rowOpen_q;
    assign openRow = openRow_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rowOpen_q <= 1'b0;
            openRow_q <= '0;
        end else if (activate) begin
            rowOpen_q <= 1'b1;
            openRow_q <= rowIn;
        end else if (precharge) begin
            rowOpen_q <= 1'b0;
        end
    end

endmodule

// ### verilog/sbba_device.sv
`timescale 1ns/10ps
module sbba_device #(
    parameter int DEVICE_WIDTH = 16,
    parameter int ROW_KEEP_BITS = 13
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic cke,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [1:0] bankSel,
    input wire logic [12:0] addr,
    input wire logic dataMaskLowByte,
    input wire logic dataMaskHighByte,
    input wire logic [15:0] dqIn,
    output logic [15:0] dqOut,
    output logic [1:0] dqOe,
    output logic [3:0] bankOpen,
    output logic burstActive,
    output logic powerDown,
    output logic [12:0] refreshRow
);
    // ****************************************
    // geometry of the selected width variant
    // ****************************************
    // column width per variant
    localparam int COL_BITS = sbba_pkg::col_bits(DEVICE_WIDTH);
    localparam int IDX_W = sbba_pkg::BANK_BITS + ROW_KEEP_BITS + COL_BITS;
    localparam int MEM_DEPTH = 1 << IDX_W;
    localparam int ENTRY_W = IDX_W + sbba_pkg::LANE_COUNT + sbba_pkg::DQ_WIDTH;
    localparam logic [11:0] COL_MAX = 12'((1 << COL_BITS) - 1);
    localparam bit IS_X16 = DEVICE_WIDTH == 16;

    sbba_pkg::sbba_cmd_type cmd;
    sbba_pkg::sbba_burst_type burstState_q;

    logic [12:0] mode_q;
    logic [11:0] burstLength;
    logic [11:0] wrLast;
    logic pagePick;
    logic clThree;
    logic [11:0] colIn;
    logic [11:0] curCol;
    logic [11:0] startCol_q;
    logic [11:0] beat_q;
    logic [11:0] lenLast_q;
    logic interleave_q;
    logic page_q;
    logic autoPre_q;
    logic [1:0] burstBank_q;
    logic [3:0] rowOpen;
    logic [12:0] openRow [sbba_pkg::BANK_COUNT];
    logic [3:0] activateVec;
    logic [3:0] prechargeVec;
    logic colCmd;
    logic cmdRead;
    logic cmdWrite;
    logic advance;
    logic stopBurst;
    logic burstEnd;
    logic apClose;
    logic apSingle;
    logic allIdle;
    logic writeBeat;
    logic fifoInReady;
    logic drainValid;
    logic drainReady;
    logic [1:0] maskNow;
    logic [IDX_W-1:0] pushIdx;
    logic [IDX_W-1:0] readIdx;
    logic [IDX_W-1:0] drainIdx;
    logic [ENTRY_W-1:0] pushEntry;
    logic [ENTRY_W-1:0] drainEntry;
    logic [15:0] mem_q [MEM_DEPTH];
    logic [15:0] st1Data_q;
    logic [15:0] st2Data_q;
    logic st1Valid_q;
    logic st2Valid_q;
    logic [1:0] dqm1_q;
    logic [1:0] dqm2_q;
    logic [15:0] dqOut_q;
    logic [1:0] dqOe_q;
    logic powerDown_q;
    logic [12:0] refreshRow_q;

    // bank, kept row bits and column form the word index
    function automatic logic [IDX_W-1:0] toIdx(
        input logic [1:0] b,
        input logic [12:0] r,
        input logic [11:0] c
    );
        return {b, r[ROW_KEEP_BITS-1:0], c[COL_BITS-1:0]};
    endfunction

    // ****************************************
    // command decode
    // ****************************************
    // commands act only at rising edges
    // strobes sampled together give the command
    always_comb begin
        cmd = sbba_pkg::CMD_NOP;
        // deselect and clock-low cycles issue nothing
        if (!csN && cke) begin
            unique case ({rasN, casN, weN})
                sbba_pkg::CODE_NOP: cmd = sbba_pkg::CMD_NOP;
                sbba_pkg::CODE_ACTIVE: cmd = sbba_pkg::CMD_ACTIVE;
                sbba_pkg::CODE_READ: cmd = sbba_pkg::CMD_READ;
                sbba_pkg::CODE_WRITE: cmd = sbba_pkg::CMD_WRITE;
                sbba_pkg::CODE_TERMINATE: cmd = sbba_pkg::CMD_TERMINATE;
                sbba_pkg::CODE_PRECHARGE: cmd = sbba_pkg::CMD_PRECHARGE;
                sbba_pkg::CODE_REFRESH: cmd = sbba_pkg::CMD_REFRESH;
                sbba_pkg::CODE_LOAD_MODE: cmd = sbba_pkg::CMD_LOAD_MODE;
            endcase
        end
    end

    assign cmdRead = cmd == sbba_pkg::CMD_READ;
    assign cmdWrite = cmd == sbba_pkg::CMD_WRITE;
    // column commands to a closed bank are dropped
    assign colCmd = (cmdRead || cmdWrite) && rowOpen[bankSel];
    assign allIdle = rowOpen == '0 && burstState_q == sbba_pkg::BURST_IDLE;

    // column bits above A9 depend on the width variant
    assign colIn = {COL_BITS > 11 ? addr[12] : 1'b0, COL_BITS > 10 ? addr[11] : 1'b0, addr[9:0]};

    // ****************************************
    // mode register
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= sbba_pkg::MODE_RESET;
        end else if (cmd == sbba_pkg::CMD_LOAD_MODE && allIdle) begin
            mode_q <= addr;
        end
    end

    // burst length code to last beat index
    always_comb begin
        pagePick = 1'b0;
        case (mode_q[sbba_pkg::MODE_LEN_LSB +: 3])
            sbba_pkg::BURST_CODE_2: burstLength = 12'h001;
            sbba_pkg::BURST_CODE_4: burstLength = 12'h003;
            sbba_pkg::BURST_CODE_8: burstLength = 12'h007;
            sbba_pkg::BURST_CODE_PAGE: begin
                burstLength = COL_MAX;
                pagePick = 1'b1;
            end
            default: burstLength = 12'h000;
        endcase
    end

    // single-write mode shortens writes to one location
    assign wrLast = mode_q[sbba_pkg::MODE_SINGLE_WRITE_BIT] ? 12'h000 : burstLength;
    assign clThree = mode_q[sbba_pkg::MODE_LAT_LSB +: 3] == sbba_pkg::LATENCY_THREE;

    // ****************************************
    // burst engine
    // ****************************************
    // wrap inside the burst block, or interleave by xor
    always_comb begin
        if (interleave_q && !page_q) begin
            curCol = startCol_q ^ beat_q;
        end else begin
            curCol = (startCol_q & ~lenLast_q) | ((startCol_q + beat_q) & lenLast_q);
        end
    end

    // clock low suspends the burst; a full queue stalls writes
    assign advance = burstState_q != sbba_pkg::BURST_IDLE && cke
                   && (burstState_q == sbba_pkg::BURST_READ || fifoInReady);
    // terminate, or precharge of the bursting bank, stops it
    assign stopBurst = cmd == sbba_pkg::CMD_TERMINATE
                     || (cmd == sbba_pkg::CMD_PRECHARGE
                         && (addr[sbba_pkg::PRECHARGE_SCOPE_BIT] || bankSel == burstBank_q));
    assign burstEnd = advance && beat_q == lenLast_q && !page_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            burstState_q <= sbba_pkg::BURST_IDLE;
            beat_q <= '0;
            startCol_q <= '0;
            lenLast_q <= '0;
            interleave_q <= 1'b0;
            page_q <= 1'b0;
            autoPre_q <= 1'b0;
            burstBank_q <= '0;
        // a new column command replaces the running burst
        end else if (colCmd) begin
            burstBank_q <= bankSel;
            startCol_q <= colIn;
            interleave_q <= mode_q[sbba_pkg::MODE_TYPE_BIT];
            autoPre_q <= addr[sbba_pkg::PRECHARGE_SCOPE_BIT];
            if (cmdRead) begin
                burstState_q <= sbba_pkg::BURST_READ;
                beat_q <= 12'h000;
                lenLast_q <= burstLength;
                page_q <= pagePick;
            end else begin
                burstState_q <= wrLast == 12'h000 ? sbba_pkg::BURST_IDLE : sbba_pkg::BURST_WRITE;
                beat_q <= 12'h001;
                lenLast_q <= wrLast;
                page_q <= pagePick && !mode_q[sbba_pkg::MODE_SINGLE_WRITE_BIT];
            end
        end else if (stopBurst || burstEnd) begin
            burstState_q <= sbba_pkg::BURST_IDLE;
        end else if (advance) begin
            beat_q <= beat_q + 12'h001;
        end
    end

    assign burstActive = burstState_q != sbba_pkg::BURST_IDLE;

    // ****************************************
    // banks
    // ****************************************
    // auto precharge fires when the burst completes or a new column command cuts it
    assign apClose = autoPre_q && burstActive && (burstEnd || colCmd);
    assign apSingle = colCmd && cmdWrite && addr[sbba_pkg::PRECHARGE_SCOPE_BIT] && wrLast == 12'h000;

    // every bank opens and closes on its own
    for (genvar b = 0; b < sbba_pkg::BANK_COUNT; b++) begin : g_bank
        // activate latches the row for the selected bank
        assign activateVec[b] = cmd == sbba_pkg::CMD_ACTIVE && bankSel == 2'(b);
        // scope bit high closes all banks
        assign prechargeVec[b] = (cmd == sbba_pkg::CMD_PRECHARGE
                                  && (addr[sbba_pkg::PRECHARGE_SCOPE_BIT] || bankSel == 2'(b)))
                               || (apClose && burstBank_q == 2'(b))
                               || (apSingle && bankSel == 2'(b));
        // a second activate simply replaces the open row
        sbba_bank u_bank (
            .core_clk(core_clk),
            .rstn(rstn),
            .activate(activateVec[b]),
            .precharge(prechargeVec[b]),
            .rowIn(addr),
            .rowOpen(rowOpen[b]),
            .openRow(openRow[b])
        );
    end

    assign bankOpen = rowOpen;

    // ****************************************
    // write path through the queue
    // ****************************************
    // a high mask blocks that byte of write data
    assign maskNow = {dataMaskHighByte, IS_X16 ? dataMaskLowByte : dataMaskHighByte};
    assign writeBeat = (colCmd && cmdWrite)
                     || (burstState_q == sbba_pkg::BURST_WRITE && advance && !stopBurst && !colCmd);
    assign pushIdx = colCmd ? toIdx(bankSel, openRow[bankSel], colIn)
                            : toIdx(burstBank_q, openRow[burstBank_q], curCol);
    assign pushEntry = {pushIdx, maskNow, dqIn};

    sbba_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(sbba_pkg::FIFO_DEPTH)
    ) u_write_queue (
        .core_clk(core_clk),
        .rstn(rstn),
        .inValid(writeBeat),
        .inReady(fifoInReady),
        .inData(pushEntry),
        .outValid(drainValid),
        .outReady(drainReady),
        .outData(drainEntry)
    );

    // the single array port serves reads first
    assign drainReady = burstState_q != sbba_pkg::BURST_READ;
    assign drainIdx = drainEntry[ENTRY_W-1 -: IDX_W];

    always_ff @(posedge core_clk) begin
        for (int lane = 0; lane < sbba_pkg::LANE_COUNT; lane++) begin
            if (drainValid && drainReady && !drainEntry[sbba_pkg::DQ_WIDTH + lane]) begin
                mem_q[drainIdx][lane*8 +: 8] <= drainEntry[lane*8 +: 8];
            end
        end
    end

    // ****************************************
    // read path and output latency
    // ****************************************
    assign readIdx = toIdx(burstBank_q, openRow[burstBank_q], curCol);

    always_ff @(posedge core_clk) begin
        st1Data_q <= mem_q[readIdx];
        st2Data_q <= st1Data_q;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st1Valid_q <= 1'b0;
            st2Valid_q <= 1'b0;
        end else begin
            st1Valid_q <= burstState_q == sbba_pkg::BURST_READ && cke;
            st2Valid_q <= st1Valid_q;
        end
    end

    // read mask takes effect two clocks after sampling
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dqm1_q <= '0;
            dqm2_q <= '0;
            dqOut_q <= '0;
            dqOe_q <= '0;
        end else begin
            dqm1_q <= maskNow;
            dqm2_q <= dqm1_q;
            dqOut_q <= clThree ? st2Data_q : st1Data_q;
            dqOe_q <= {2{clThree ? st2Valid_q : st1Valid_q}} & ~dqm2_q;
        end
    end

    assign dqOut = dqOut_q;
    assign dqOe = dqOe_q;

    // ****************************************
    // refresh and power-down
    // ****************************************
    // refresh steps the row counter, clock low powers down
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            refreshRow_q <= '0;
        end else if (cmd == sbba_pkg::CMD_REFRESH && allIdle) begin
            refreshRow_q <= refreshRow_q + 13'h0001;
        end
    end

    // power-down only with no burst running, open rows allowed; a burst is suspended instead
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            powerDown_q <= 1'b0;
        end else begin
            powerDown_q <= !cke && (powerDown_q || !burstActive);
        end
    end

    assign powerDown = powerDown_q;
    assign refreshRow = refreshRow_q;

endmodule

// ### sim/sbba_device_checker.sv
`timescale 1ns/10ps
// ****************************************
// port checks of the device
// ****************************************
module sbba_device_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic cke,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [1:0] bankSel,
    input wire logic [12:0] addr,
    input wire logic dataMaskLowByte,
    input wire logic dataMaskHighByte,
    input wire logic [1:0] dqOe,
    input wire logic [3:0] bankOpen,
    input wire logic burstActive,
    input wire logic powerDown
);
    logic [2:0] code;
    logic take;
    logic clThree_q;
    assign code = {rasN, casN, weN};
    assign take = !csN && cke;
    // latency follows the last accepted mode load
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clThree_q <= 1'b0;
        end else if (take && code == sbba_pkg::CODE_LOAD_MODE && bankOpen == 4'h0 && !burstActive) begin
            clThree_q <= addr[6:4] == sbba_pkg::LATENCY_THREE;
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    property p_act;
        take && code == sbba_pkg::CODE_ACTIVE |=> bankOpen[$past(bankSel)];
    endproperty
    a_act: assert property (p_act) else $error("activate left bank closed");
    property p_cs;
        csN && bankOpen == 4'h0 |=> bankOpen == 4'h0;
    endproperty
    a_cs: assert property (p_cs) else $error("deselected command took effect");
    property p_pre_all;
        take && code == sbba_pkg::CODE_PRECHARGE && addr[10] |=> bankOpen == 4'h0;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");
    property p_pre_one;
        take && code == sbba_pkg::CODE_PRECHARGE && !addr[10] |=> !bankOpen[$past(bankSel)];
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("bank precharge left bank open");
    property p_mask_lo;
        dataMaskLowByte |-> ##3 !dqOe[0];
    endproperty
    a_mask_lo: assert property (p_mask_lo) else $error("low lane driven under mask");
    property p_mask_hi;
        dataMaskHighByte |-> ##3 !dqOe[1];
    endproperty
    a_mask_hi: assert property (p_mask_hi) else $error("high lane driven under mask");
    property p_pd_in;
        !cke && !burstActive |=> powerDown;
    endproperty
    a_pd_in: assert property (p_pd_in) else $error("power-down not entered");
    property p_pd_out;
        cke && powerDown |=> !powerDown;
    endproperty
    a_pd_out: assert property (p_pd_out) else $error("power-down not left");
    property p_rd_lat;
        take && code == sbba_pkg::CODE_READ && bankOpen[bankSel] && !clThree_q && !dataMaskLowByte ##1 cke
            |=> ##1 dqOe[0];
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read word missing two cycles on");
endmodule
bind sbba_device sbba_device_checker u_chk (.core_clk, .rstn, .cke, .csN, .rasN, .casN, .weN, .bankSel, .addr,
    .dataMaskLowByte, .dataMaskHighByte, .dqOe, .bankOpen, .burstActive, .powerDown);

// ### sim/sbba_ctrl_model.sv
`timescale 1ns/10ps
// ****************************************
// controller driving command and data pins
// ****************************************
module sbba_ctrl_model (
    input wire logic core_clk,
    output logic cke,
    output logic csN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic [1:0] bankSel,
    output logic [12:0] addr,
    output logic maskLow,
    output logic maskHigh,
    output logic [15:0] dqIn
);
    logic [12:0] openRow [4];
    logic [3:0] rowValid;
    initial begin
        cke = 1'b1;
        {csN, rasN, casN, weN} = 4'hF;
        bankSel = 2'h0;
        addr = 13'h0000;
        {maskHigh, maskLow} = 2'h0;
        dqIn = 16'h0000;
        rowValid = 4'h0;
    end
    task automatic issue(input logic [3:0] code, input logic [1:0] b, input logic [12:0] a,
        input logic [15:0] d, input logic [1:0] m);
        @(negedge core_clk);
        {csN, rasN, casN, weN} = code;
        bankSel = b;
        addr = a;
        dqIn = d;
        {maskHigh, maskLow} = m;
        if (code == {1'b0, sbba_pkg::CODE_ACTIVE}) begin
            rowValid[b] = 1'b1;
            openRow[b] = a;
        end else if (code == {1'b0, sbba_pkg::CODE_PRECHARGE}) begin
            rowValid = a[10] ? 4'h0 : rowValid & ~(4'h1 << b);
        end
    endtask
    task automatic open_row(input logic [1:0] b, input logic [12:0] r);
        if (rowValid[b] && openRow[b] != r) begin
            issue({1'b0, sbba_pkg::CODE_PRECHARGE}, b, 13'h0000, ~dqIn, 2'h0);
        end
        issue({1'b0, sbba_pkg::CODE_ACTIVE}, b, r, ~dqIn, 2'h0);
    endtask
    task automatic power(input logic v);
        @(negedge core_clk);
        cke = v;
    endtask
endmodule

// ### sim/sbba_device_bench.sv
`timescale 1ns/10ps
module sbba_device_bench;
    localparam logic [3:0] C_NOP = {1'b0, sbba_pkg::CODE_NOP};
    localparam logic [3:0] C_RD = {1'b0, sbba_pkg::CODE_READ};
    localparam logic [3:0] C_WR = {1'b0, sbba_pkg::CODE_WRITE};
    localparam logic [3:0] C_TRM = {1'b0, sbba_pkg::CODE_TERMINATE};
    localparam logic [3:0] C_PRE = {1'b0, sbba_pkg::CODE_PRECHARGE};
    localparam logic [3:0] C_REF = {1'b0, sbba_pkg::CODE_REFRESH};
    localparam logic [3:0] C_LMR = {1'b0, sbba_pkg::CODE_LOAD_MODE};
    logic core_clk, rstn, cke, csN, rasN, casN, weN, mLo, mHi, burstActive, powerDown;
    logic [1:0] bankSel, dqOe;
    logic [12:0] addr, refreshRow;
    logic [15:0] dqIn, dqOut;
    logic [3:0] bankOpen;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    sbba_device #(.DEVICE_WIDTH(16), .ROW_KEEP_BITS(4)) DUT (.core_clk, .rstn, .cke, .csN, .rasN, .casN, .weN,
        .bankSel, .addr, .dataMaskLowByte(mLo), .dataMaskHighByte(mHi), .dqIn, .dqOut, .dqOe, .bankOpen,
        .burstActive, .powerDown, .refreshRow);
    sbba_ctrl_model P (.core_clk, .cke, .csN, .rasN, .casN, .weN, .bankSel, .addr, .maskLow(mLo),
        .maskHigh(mHi), .dqIn);
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic [3:0] code, input logic [1:0] b, input logic [12:0] a);
        P.issue(code, b, a, ~P.dqIn, 2'h0);
    endtask
    task automatic t_lengths;
        logic [2:0] lens [5] = '{3'h0, sbba_pkg::BURST_CODE_2, sbba_pkg::BURST_CODE_4, sbba_pkg::BURST_CODE_8,
            sbba_pkg::BURST_CODE_PAGE};
        int exp [5] = '{1, 2, 4, 8, 3};
        int n;
        for (int i = 0; i < 5; i++) begin
            n = 0;
            cmd(C_PRE, 2'h0, 13'h0400);
            cmd(C_LMR, 2'h0, {10'h000, lens[i]});
            P.open_row(2'h0, 13'h0002);
            cmd(C_RD, 2'h0, 13'h0000);
            for (int j = 0; j < 14; j++) begin
                cmd((i == 4 && j == 2) ? C_TRM : C_NOP, 2'h0, 13'h0000);
                n += int'(dqOe === 2'h3);
            end
            check("burst beats", 16'(n), 16'(exp[i]));
        end
    endtask
    task automatic t_data;
        logic [15:0] exp [4] = '{16'hA052, 16'h5503, 16'hA000, 16'hA001};
        cmd(C_PRE, 2'h0, 13'h0400);
        cmd(C_LMR, 2'h0, {10'h000, sbba_pkg::BURST_CODE_4});
        P.open_row(2'h1, 13'h0005);
        P.open_row(2'h2, 13'h0001);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                P.issue(k == 0 ? C_WR : C_NOP, 2'h1, 13'h0004, (p == 1 ? 16'hA000 : 16'h5550) + 16'(k),
                    (p == 1 && k > 1) ? 2'(k - 1) : 2'h0);
            end
        end
        cmd(C_NOP, 2'h0, 13'h0000);
        cmd(C_NOP, 2'h0, 13'h0000);
        cmd(C_RD, 2'h1, 13'h0406);
        cmd(C_PRE, 2'h2, 13'h0000);
        cmd(C_NOP, 2'h0, 13'h0000);
        for (int k = 0; k < 4; k++) begin
            cmd(C_NOP, 2'h0, 13'h0000);
            check("read word", dqOut, exp[k]);
        end
        cmd(C_NOP, 2'h0, 13'h0000);
        check("banks closed", 16'(bankOpen), 16'h0000);
    endtask
    task automatic t_cs;
        cmd({1'b1, sbba_pkg::CODE_ACTIVE}, 2'h3, 13'h0007);
        cmd(C_NOP, 2'h0, 13'h0000);
        check("deselected", 16'(bankOpen), 16'h0000);
        P.open_row(2'h3, 13'h0007);
        cmd(C_NOP, 2'h0, 13'h0000);
        check("activated", 16'(bankOpen), 16'h0008);
    endtask
    task automatic t_power;
        logic [12:0] r0;
        cmd(C_PRE, 2'h0, 13'h0400);
        cmd(C_NOP, 2'h0, 13'h0000);
        r0 = refreshRow;
        cmd(C_REF, 2'h0, 13'h0000);
        cmd(C_NOP, 2'h0, 13'h0000);
        check("refresh row", 16'(refreshRow), 16'(r0 + 13'h0001));
        P.power(1'b0);
        cmd(C_NOP, 2'h0, 13'h0000);
        check("power down", 16'(powerDown), 16'h0001);
        P.power(1'b1);
        cmd(C_NOP, 2'h0, 13'h0000);
        check("power up", 16'(powerDown), 16'h0000);
    endtask
    task automatic t_queue;
        cmd(C_PRE, 2'h0, 13'h0400);
        cmd(C_LMR, 2'h0, 13'h003B);
        P.open_row(2'h0, 13'h0003);
        for (int k = 0; k < 8; k++) begin
            P.issue(k == 0 ? C_WR : C_NOP, 2'h0, 13'h0010, 16'h3C40 + 16'(k), 2'h0);
        end
        cmd(C_RD, 2'h0, 13'h0013);
        for (int j = 0; j < 11; j++) begin
            P.issue(C_NOP, 2'h0, 13'h0000, ~P.dqIn, j == 2 ? 2'h1 : 2'h0);
            if (j > 2) begin
                check("queued word", dqOut, 16'h3C40 + 16'(3 ^ (j - 3)));
                check("read mask", 16'(dqOe), j == 5 ? 16'h0002 : 16'h0003);
            end
        end
        check("burst over", 16'(burstActive), 16'h0000);
    endtask
    // ****************************************
    // clock, reset and run
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        rstn = 1'b0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        check("reset state", {8'h00, bankOpen, burstActive, powerDown, dqOe}, 16'h0000);
        rstn = 1'b1;
        t_lengths();
        t_data();
        t_cs();
        t_power();
        t_queue();
        wrap_up();
    end
endmodule
